// ==== rtl/dsm_pkg.sv ====
package dsm_pkg;
   // operating modes, gray coded along shutdown->standby->dp->d3
   typedef enum logic [2:0] {
      DSM_SHUTDOWN = 3'h0,
      DSM_STANDBY  = 3'h1,
      DSM_DP_ACT   = 3'h3,
      DSM_D3       = 3'h2,
      DSM_HDMI_ACT = 3'h6
   } dsm_mode_t;

   localparam int unsigned CLK_HZ          = 20_000_000;
   // least hot-plug low time in microseconds
   localparam int unsigned HPD_LOW_US      = 2000;
   localparam int unsigned HPD_LOW_CYC     =
      (HPD_LOW_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CNT_W           = 20;

   // swing code for 600 mVpp
   localparam logic [1:0]  SWING_600MV     = 2'h1;
   localparam logic [1:0]  SWING_RST       = 2'h0;
   localparam logic [1:0]  PREEMPH_RST     = 2'h0;
   localparam logic [1:0]  EQ_RST          = 2'h0;

   // monitored aux command encodings
   localparam logic [2:0]  AUXC_NONE       = 3'h0;
   localparam logic [2:0]  AUXC_TRAIN_SET  = 3'h1;
   localparam logic [2:0]  AUXC_TRAIN_DONE = 3'h2;
   localparam logic [2:0]  AUXC_ENTER_D3   = 3'h3;
   localparam logic [2:0]  AUXC_EXIT_D3    = 3'h4;
   localparam logic [2:0]  AUXC_TRAIN_LOST = 3'h5;

   // adaptor id buffer
   localparam logic [7:0]  ADPT_WR_ADDR    = 8'h80;
   localparam logic [7:0]  ADPT_RD_ADDR    = 8'h81;
   localparam int unsigned ADPT_LEN        = 16;
   localparam logic [7:0]  ADPT_PAD        = 8'hff;
   localparam logic [4:0]  ADPT_SUB_RST    = 5'h00;
endpackage

// ==== rtl/dsm_hpd_filter.sv ====
`timescale 1ns/100ps
`default_nettype none
// hot-plug qualifier: drops only after the full low time
module dsm_hpd_filter #(
   parameter int unsigned LOW_CYC = dsm_pkg::HPD_LOW_CYC
) (
   input  wire logic I_CLK,
   input  wire logic I_RESET,
   input  wire logic i_ce,
   input  wire logic i_clr,
   input  wire logic i_hpd,
   output logic      o_present
);
   logic [dsm_pkg::CNT_W-1:0] low_cnt_ff;

   always_ff @(posedge I_CLK) begin
      if (I_RESET || i_clr) begin
         low_cnt_ff <= '0;
         o_present  <= 1'b0;
      end else if (i_ce) begin
         if (i_hpd) begin
            low_cnt_ff <= '0;
            o_present  <= 1'b1;
         end else if (low_cnt_ff >= dsm_pkg::CNT_W'(LOW_CYC - 1)) begin
            o_present  <= 1'b0; // [RULE15]
         end else begin
            low_cnt_ff <= low_cnt_ff + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/dsm_adaptor_id.sv ====
`timescale 1ns/100ps
`default_nettype none
// read-only adaptor id table; sub-address set by writes to 80h
module dsm_adaptor_id (
   input  wire logic       I_CLK,
   input  wire logic       I_RESET,
   input  wire logic       i_ce,
   input  wire logic       i_en,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_dev_addr,
   input  wire logic [7:0] i_wdata,
   output logic [7:0]      o_rdata,
   output logic            o_rvalid
);
   logic [4:0] sub_ff;
   logic [7:0] rom_byte;

   always_comb begin
      case (sub_ff)
         5'h00: rom_byte = 8'h44;
         5'h01: rom_byte = 8'h50;
         5'h02: rom_byte = 8'h2d;
         5'h03: rom_byte = 8'h48;
         5'h04: rom_byte = 8'h44;
         5'h05: rom_byte = 8'h4d;
         5'h06: rom_byte = 8'h49;
         5'h07: rom_byte = 8'h20;
         5'h08: rom_byte = 8'h41;
         5'h09: rom_byte = 8'h44;
         5'h0a: rom_byte = 8'h41;
         5'h0b: rom_byte = 8'h50;
         5'h0c: rom_byte = 8'h54;
         5'h0d: rom_byte = 8'h4f;
         5'h0e: rom_byte = 8'h52;
         5'h0f: rom_byte = 8'h04;
         default: rom_byte = dsm_pkg::ADPT_PAD;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET || !i_en) begin
         sub_ff   <= dsm_pkg::ADPT_SUB_RST;
         o_rdata  <= 8'h00;
         o_rvalid <= 1'b0;
      end else if (i_ce) begin
         o_rvalid <= 1'b0;
         // writes only move the pointer
         if (i_wr && i_dev_addr == dsm_pkg::ADPT_WR_ADDR) begin
            sub_ff <= i_wdata[4:0]; // [RULE22]
         end else if (i_rd && i_dev_addr == dsm_pkg::ADPT_RD_ADDR) begin
            o_rdata  <= rom_byte; // [RULE22]
            o_rvalid <= 1'b1;
            if (sub_ff != 5'h1f) begin
               sub_ff <= sub_ff + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/dsm_mode_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RULE1] enable low forces shutdown, the lowest power mode
// [RULE2] shutdown still raises source hot-plug if either sink hot-plug high
// [RULE3] shutdown floats other outputs, ignores inputs, local i2c inactive; O_EQ still follows I_EQ_CTRL in shutdown
// [RULE4] shutdown returns i2c configuration and link settings to defaults
// [RULE5] standby disables main link outputs, local i2c stays active
// [RULE6] standby holds source hot-plug and cable-detect low for minimum time
// [RULE7] standby when no sink, or passed through on preference switch
// [RULE8] dp active selects dp sink; cable-detect picks tmds or dp signalling
// [RULE9] tmds sub-mode routes source ddc to sink aux; cable-detect out high
// [RULE10] tmds sub-mode swing defaults to 600 mVpp unless i2c overrides
// [RULE11] dp sub-mode routes source aux to sink aux; cable-detect out low
// [RULE12] aux monitor training enables outputs; i2c may disable and override
// [RULE13] aux monitor ignores all but training and d3 commands
// [RULE14] dp sub-mode conditioning from training, inputs and i2c settings
// [RULE15] dp active needs dp hot-plug; tolerates short low pulses
// [RULE16] both sinks present, preference low selects dp sink
// [RULE17] both sinks present, preference high selects hdmi sink
// [RULE18] d3 disables dp main link; i2c and aux monitor remain active
// [RULE19] d3 entered only from dp sub-mode after enter-d3 aux command
// [RULE20] hdmi active needs hdmi hot-plug; selects hdmi, enables its link
// [RULE21] hdmi active couples source ddc to sink ddc through i2c buffer
// [RULE22] hdmi active exposes read-only adaptor id at 80h write, 81h read
module dsm_mode_ctrl #(
   parameter int unsigned HPD_LOW_CYC = dsm_pkg::HPD_LOW_CYC
) (
   input  wire logic       I_CLK,
   input  wire logic       I_RESET,
   input  wire logic       I_CE,
   input  wire logic       I_CHIP_EN,
   input  wire logic       I_DP_SINK_HOTPLUG_IN,
   input  wire logic       I_HDMI_SINK_HOTPLUG_IN,
   input  wire logic       I_SINK_CABLE_DETECT_IN,
   input  wire logic       I_SINK_PREF,
   input  wire logic [1:0] I_EQ_CTRL,
   input  wire logic       I_CFG_WR,
   input  wire logic       I_CFG_TRAIN_DIS,
   input  wire logic       I_CFG_OVR_EN,
   input  wire logic [1:0] I_CFG_SWING,
   input  wire logic [1:0] I_CFG_PREEMPH,
   input  wire logic [1:0] I_CFG_EQ,
   input  wire logic       I_AUX_VALID,
   input  wire logic [2:0] I_AUX_CMD,
   input  wire logic [1:0] I_AUX_SWING,
   input  wire logic [1:0] I_AUX_PREEMPH,
   input  wire logic       I_DDC_WR,
   input  wire logic       I_DDC_RD,
   input  wire logic [7:0] I_DDC_DEV_ADDR,
   input  wire logic [7:0] I_DDC_WDATA,
   output logic [2:0]      O_MODE,
   output logic            O_SOURCE_HOTPLUG_OUT,
   output logic            O_SOURCE_CABLE_DETECT_OUT,
   output logic            O_SOURCE_CABLE_DETECT_OE,
   output logic            O_DP_LINK_EN,
   output logic            O_HDMI_LINK_EN,
   output logic            O_TMDS_SIGNALLING,
   output logic            O_SRC_DDC_TO_SINK_AUX,
   output logic            O_SRC_AUX_TO_SINK_AUX,
   output logic            O_DDC_BUFFER_EN,
   output logic            O_I2C_ACTIVE,
   output logic            O_AUX_MON_ACTIVE,
   output logic [1:0]      O_SWING,
   output logic [1:0]      O_PREEMPH,
   output logic [1:0]      O_EQ,
   output logic [7:0]      O_ADPT_RDATA,
   output logic            O_ADPT_RVALID
);
   dsm_pkg::dsm_mode_t mode_ff;
   dsm_pkg::dsm_mode_t nxt_mode;
   logic                      dp_present;
   logic                      hdmi_present;
   logic                      shut;
   logic [dsm_pkg::CNT_W-1:0] stby_cnt_ff;
   logic                      stby_done;
   logic                      want_dp;
   logic                      want_hdmi;
   logic                      sel_dp_ff;
   logic                      d3_req_ff;
   logic                      trained_ff;
   logic [1:0]                tr_swing_ff;
   logic [1:0]                tr_preemph_ff;
   logic                      cfg_train_dis_ff;
   logic                      cfg_ovr_ff;
   logic [1:0]                cfg_swing_ff;
   logic [1:0]                cfg_preemph_ff;
   logic [1:0]                cfg_eq_ff;
   logic                      aux_cmd_ok;
   logic                      dp_mode;
   logic [7:0]                adpt_rdata;
   logic                      adpt_rvalid;

   assign shut = !I_CHIP_EN; // [RULE1]
   assign dp_mode = (mode_ff == dsm_pkg::DSM_DP_ACT) ||
                    (mode_ff == dsm_pkg::DSM_D3);

   dsm_hpd_filter #(
      .LOW_CYC (HPD_LOW_CYC)
   ) u_dp_hpd (
      .I_CLK     (I_CLK),
      .I_RESET   (I_RESET),
      .i_ce      (I_CE),
      .i_clr     (shut),
      .i_hpd     (I_DP_SINK_HOTPLUG_IN),
      .o_present (dp_present)
   );

   dsm_hpd_filter #(
      .LOW_CYC (HPD_LOW_CYC)
   ) u_hdmi_hpd (
      .I_CLK     (I_CLK),
      .I_RESET   (I_RESET),
      .i_ce      (I_CE),
      .i_clr     (shut),
      .i_hpd     (I_HDMI_SINK_HOTPLUG_IN),
      .o_present (hdmi_present)
   );

   dsm_adaptor_id u_adpt (
      .I_CLK      (I_CLK),
      .I_RESET    (I_RESET),
      .i_ce       (I_CE),
      .i_en       (mode_ff == dsm_pkg::DSM_HDMI_ACT), // [RULE22]
      .i_wr       (I_DDC_WR),
      .i_rd       (I_DDC_RD),
      .i_dev_addr (I_DDC_DEV_ADDR),
      .i_wdata    (I_DDC_WDATA),
      .o_rdata    (adpt_rdata),
      .o_rvalid   (adpt_rvalid)
   );

   // preference only matters with both sinks present
   always_comb begin
      want_dp   = 1'b0;
      want_hdmi = 1'b0;
      if (dp_present && hdmi_present) begin
         want_dp   = !I_SINK_PREF; // [RULE16]
         want_hdmi = I_SINK_PREF; // [RULE17]
      end else begin
         want_dp   = dp_present; // [RULE15]
         want_hdmi = hdmi_present; // [RULE20]
      end
   end

   assign stby_done = (stby_cnt_ff >= dsm_pkg::CNT_W'(HPD_LOW_CYC - 1));

   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         dsm_pkg::DSM_SHUTDOWN: begin
            nxt_mode = dsm_pkg::DSM_STANDBY;
         end
         dsm_pkg::DSM_STANDBY: begin
            // leave only after the full low pulse
            if (stby_done && want_dp) begin // [RULE6]
               nxt_mode = dsm_pkg::DSM_DP_ACT; // [RULE8]
            end else if (stby_done && want_hdmi) begin
               nxt_mode = dsm_pkg::DSM_HDMI_ACT; // [RULE20]
            end
         end
         dsm_pkg::DSM_DP_ACT: begin
            if (!want_dp) begin
               nxt_mode = dsm_pkg::DSM_STANDBY; // [RULE7]
            end else if (d3_req_ff && !I_SINK_CABLE_DETECT_IN) begin
               nxt_mode = dsm_pkg::DSM_D3; // [RULE19]
            end
         end
         dsm_pkg::DSM_D3: begin
            if (!want_dp) begin
               nxt_mode = dsm_pkg::DSM_STANDBY; // [RULE7]
            end else if (!d3_req_ff) begin
               nxt_mode = dsm_pkg::DSM_DP_ACT;
            end
         end
         dsm_pkg::DSM_HDMI_ACT: begin
            if (!want_hdmi) begin
               nxt_mode = dsm_pkg::DSM_STANDBY; // [RULE7]
            end
         end
         default: nxt_mode = dsm_pkg::DSM_SHUTDOWN;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         mode_ff <= dsm_pkg::DSM_SHUTDOWN;
      end else if (I_CE) begin
         if (shut) begin
            mode_ff <= dsm_pkg::DSM_SHUTDOWN; // [RULE1]
         end else begin
            mode_ff <= nxt_mode;
         end
      end
   end

   // standby low-pulse counter
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         stby_cnt_ff <= '0;
      end else if (I_CE) begin
         if (shut || mode_ff != dsm_pkg::DSM_STANDBY) begin
            stby_cnt_ff <= '0;
         end else if (!stby_done) begin
            stby_cnt_ff <= stby_cnt_ff + 1'b1; // [RULE6]
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         sel_dp_ff <= 1'b0;
      end else if (I_CE) begin
         sel_dp_ff <= (nxt_mode == dsm_pkg::DSM_DP_ACT) ||
                      (nxt_mode == dsm_pkg::DSM_D3);
      end
   end

   // local i2c config; cleared in shutdown
   always_ff @(posedge I_CLK) begin
      if (I_RESET || (I_CE && shut)) begin
         cfg_train_dis_ff <= 1'b0; // [RULE4]
         cfg_ovr_ff       <= 1'b0;
         cfg_swing_ff     <= dsm_pkg::SWING_RST;
         cfg_preemph_ff   <= dsm_pkg::PREEMPH_RST;
         cfg_eq_ff        <= dsm_pkg::EQ_RST;
      end else if (I_CE && I_CFG_WR) begin // [RULE3]
         cfg_train_dis_ff <= I_CFG_TRAIN_DIS;
         cfg_ovr_ff       <= I_CFG_OVR_EN;
         cfg_swing_ff     <= I_CFG_SWING;
         cfg_preemph_ff   <= I_CFG_PREEMPH;
         cfg_eq_ff        <= I_CFG_EQ;
      end
   end

   // aux monitor: training and d3 only
   always_comb begin
      case (I_AUX_CMD)
         dsm_pkg::AUXC_TRAIN_SET,
         dsm_pkg::AUXC_TRAIN_DONE,
         dsm_pkg::AUXC_TRAIN_LOST,
         dsm_pkg::AUXC_ENTER_D3,
         dsm_pkg::AUXC_EXIT_D3: aux_cmd_ok = 1'b1;
         default:               aux_cmd_ok = 1'b0; // [RULE13]
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET || (I_CE && (shut || !dp_mode))) begin
         trained_ff    <= 1'b0; // [RULE4]
         tr_swing_ff   <= dsm_pkg::SWING_RST;
         tr_preemph_ff <= dsm_pkg::PREEMPH_RST;
         d3_req_ff     <= 1'b0;
      end else if (I_CE && I_AUX_VALID && aux_cmd_ok &&
                   !I_SINK_CABLE_DETECT_IN) begin // [RULE18]
         case (I_AUX_CMD)
            dsm_pkg::AUXC_TRAIN_SET: begin
               tr_swing_ff   <= I_AUX_SWING; // [RULE14]
               tr_preemph_ff <= I_AUX_PREEMPH;
            end
            dsm_pkg::AUXC_TRAIN_DONE: trained_ff <= 1'b1; // [RULE12]
            dsm_pkg::AUXC_TRAIN_LOST: trained_ff <= 1'b0;
            dsm_pkg::AUXC_ENTER_D3:   d3_req_ff  <= 1'b1; // [RULE19]
            dsm_pkg::AUXC_EXIT_D3:    d3_req_ff  <= 1'b0;
            default:                  d3_req_ff  <= d3_req_ff;
         endcase
      end
   end

   // registered pin controls
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_MODE                    <= 3'h0;
         O_SOURCE_HOTPLUG_OUT      <= 1'b0;
         O_SOURCE_CABLE_DETECT_OUT <= 1'b0;
         O_SOURCE_CABLE_DETECT_OE  <= 1'b0;
         O_DP_LINK_EN              <= 1'b0;
         O_HDMI_LINK_EN            <= 1'b0;
         O_TMDS_SIGNALLING         <= 1'b0;
         O_SRC_DDC_TO_SINK_AUX     <= 1'b0;
         O_SRC_AUX_TO_SINK_AUX     <= 1'b0;
         O_DDC_BUFFER_EN           <= 1'b0;
         O_I2C_ACTIVE              <= 1'b0;
         O_AUX_MON_ACTIVE          <= 1'b0;
      end else if (I_CE) begin
         O_MODE <= mode_ff;
         O_SOURCE_HOTPLUG_OUT      <= 1'b0;
         O_SOURCE_CABLE_DETECT_OUT <= 1'b0;
         O_SOURCE_CABLE_DETECT_OE  <= 1'b1;
         O_DP_LINK_EN              <= 1'b0; // [RULE5]
         O_HDMI_LINK_EN            <= 1'b0;
         O_TMDS_SIGNALLING         <= 1'b0;
         O_SRC_DDC_TO_SINK_AUX     <= 1'b0;
         O_SRC_AUX_TO_SINK_AUX     <= 1'b0;
         O_DDC_BUFFER_EN           <= 1'b0;
         O_I2C_ACTIVE              <= 1'b1;
         O_AUX_MON_ACTIVE          <= 1'b0;
         case (mode_ff)
            dsm_pkg::DSM_SHUTDOWN: begin
               O_SOURCE_HOTPLUG_OUT <= I_DP_SINK_HOTPLUG_IN ||
                                       I_HDMI_SINK_HOTPLUG_IN; // [RULE2]
               O_SOURCE_CABLE_DETECT_OE <= 1'b0; // [RULE3]
               O_I2C_ACTIVE             <= 1'b0;
            end
            dsm_pkg::DSM_DP_ACT: begin
               O_SOURCE_HOTPLUG_OUT <= 1'b1;
               O_AUX_MON_ACTIVE     <= !I_SINK_CABLE_DETECT_IN;
               if (I_SINK_CABLE_DETECT_IN) begin
                  O_TMDS_SIGNALLING         <= 1'b1; // [RULE8]
                  O_SRC_DDC_TO_SINK_AUX     <= 1'b1; // [RULE9]
                  O_SOURCE_CABLE_DETECT_OUT <= 1'b1;
                  O_DP_LINK_EN              <= 1'b1;
               end else begin
                  O_SRC_AUX_TO_SINK_AUX <= 1'b1; // [RULE11]
                  // local override bypasses training
                  O_DP_LINK_EN <= cfg_ovr_ff || // [RULE12]
                                  (trained_ff && !cfg_train_dis_ff);
               end
            end
            dsm_pkg::DSM_D3: begin
               O_SOURCE_HOTPLUG_OUT  <= 1'b1;
               O_SRC_AUX_TO_SINK_AUX <= 1'b1;
               O_AUX_MON_ACTIVE      <= 1'b1; // [RULE18]
            end
            dsm_pkg::DSM_HDMI_ACT: begin
               O_SOURCE_HOTPLUG_OUT <= 1'b1;
               O_SOURCE_CABLE_DETECT_OUT <= 1'b1;
               O_HDMI_LINK_EN       <= 1'b1; // [RULE20]
               O_TMDS_SIGNALLING    <= 1'b1;
               O_DDC_BUFFER_EN      <= 1'b1; // [RULE21]
            end
            default: begin
               O_SOURCE_HOTPLUG_OUT <= 1'b0; // [RULE6]
            end
         endcase
      end
   end

   // conditioning
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_SWING   <= dsm_pkg::SWING_RST;
         O_PREEMPH <= dsm_pkg::PREEMPH_RST;
         O_EQ      <= dsm_pkg::EQ_RST;
      end else if (I_CE) begin
         O_EQ <= cfg_ovr_ff ? cfg_eq_ff : I_EQ_CTRL; // [RULE10]
         if (cfg_ovr_ff) begin
            O_SWING   <= cfg_swing_ff;
            O_PREEMPH <= cfg_preemph_ff;
         end else if (dp_mode && !I_SINK_CABLE_DETECT_IN &&
                      !cfg_train_dis_ff) begin
            O_SWING   <= tr_swing_ff; // [RULE14]
            O_PREEMPH <= tr_preemph_ff;
         end else if (sel_dp_ff || mode_ff == dsm_pkg::DSM_HDMI_ACT) begin
            O_SWING   <= dsm_pkg::SWING_600MV; // [RULE10]
            O_PREEMPH <= dsm_pkg::PREEMPH_RST;
         end else begin
            O_SWING   <= dsm_pkg::SWING_RST;
            O_PREEMPH <= dsm_pkg::PREEMPH_RST;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_ADPT_RDATA  <= 8'h00;
         O_ADPT_RVALID <= 1'b0;
      end else if (I_CE) begin
         O_ADPT_RDATA  <= adpt_rdata;
         O_ADPT_RVALID <= adpt_rvalid;
      end
   end
endmodule
`default_nettype wire

// ==== tb/dsm_mode_ctrl_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module dsm_mode_ctrl_chk #(
   parameter int unsigned HPD_LOW_CYC = dsm_pkg::HPD_LOW_CYC
) (
   input wire logic       I_CLK,
   input wire logic       I_RESET,
   input wire logic       I_CHIP_EN,
   input wire logic       I_DP_SINK_HOTPLUG_IN,
   input wire logic       I_HDMI_SINK_HOTPLUG_IN,
   input wire logic       I_DDC_RD,
   input wire logic [7:0] I_DDC_DEV_ADDR,
   input wire logic [2:0] O_MODE,
   input wire logic       O_SOURCE_HOTPLUG_OUT,
   input wire logic       O_SOURCE_CABLE_DETECT_OUT,
   input wire logic       O_SOURCE_CABLE_DETECT_OE,
   input wire logic       O_DP_LINK_EN,
   input wire logic       O_HDMI_LINK_EN,
   input wire logic       O_TMDS_SIGNALLING,
   input wire logic       O_SRC_DDC_TO_SINK_AUX,
   input wire logic       O_SRC_AUX_TO_SINK_AUX,
   input wire logic       O_DDC_BUFFER_EN,
   input wire logic       O_I2C_ACTIVE,
   input wire logic       O_AUX_MON_ACTIVE,
   input wire logic       O_ADPT_RVALID
);
   logic [19:0] low_cnt_ff;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   // saturates so a long low never wraps
   always_ff @(posedge I_CLK) begin
      if (I_RESET || O_SOURCE_HOTPLUG_OUT)
         low_cnt_ff <= 20'h00000;
      else if (low_cnt_ff != 20'hfffff)
         low_cnt_ff <= low_cnt_ff + 20'h00001;
   end
   shut_mode_a: assert property (
      !I_CHIP_EN [*2] |=> O_MODE == dsm_pkg::DSM_SHUTDOWN)
      else $error("not shut down");
   shut_hpd_a: assert property (
      (!I_CHIP_EN && (I_DP_SINK_HOTPLUG_IN || I_HDMI_SINK_HOTPLUG_IN)) [*3]
      |-> O_SOURCE_HOTPLUG_OUT)
      else $error("hot-plug low in shutdown");
   shut_float_a: assert property (
      O_MODE == dsm_pkg::DSM_SHUTDOWN |-> !O_SOURCE_CABLE_DETECT_OE &&
      !O_I2C_ACTIVE && !O_DP_LINK_EN && !O_HDMI_LINK_EN)
      else $error("output active in shutdown");
   stby_off_a: assert property (
      O_MODE == dsm_pkg::DSM_STANDBY |-> !O_DP_LINK_EN && !O_HDMI_LINK_EN
      && O_I2C_ACTIVE && !O_SOURCE_HOTPLUG_OUT && !O_SOURCE_CABLE_DETECT_OUT)
      else $error("standby outputs wrong");
   hpd_low_a: assert property (
      $rose(O_SOURCE_HOTPLUG_OUT) && O_MODE != dsm_pkg::DSM_SHUTDOWN &&
      $past(O_MODE) != dsm_pkg::DSM_SHUTDOWN |-> low_cnt_ff >= HPD_LOW_CYC)
      else $error("hot-plug low too short");
   tmds_route_a: assert property (
      O_MODE == dsm_pkg::DSM_DP_ACT && O_TMDS_SIGNALLING |->
      O_SRC_DDC_TO_SINK_AUX && !O_SRC_AUX_TO_SINK_AUX &&
      O_SOURCE_CABLE_DETECT_OUT)
      else $error("tmds routing wrong");
   dp_route_a: assert property (
      O_MODE == dsm_pkg::DSM_DP_ACT && !O_TMDS_SIGNALLING |->
      O_SRC_AUX_TO_SINK_AUX && !O_SRC_DDC_TO_SINK_AUX &&
      O_SOURCE_CABLE_DETECT_OE && !O_SOURCE_CABLE_DETECT_OUT)
      else $error("dp routing wrong");
   d3_state_a: assert property (
      O_MODE == dsm_pkg::DSM_D3 |-> !O_DP_LINK_EN && O_I2C_ACTIVE &&
      O_AUX_MON_ACTIVE)
      else $error("d3 outputs wrong");
   d3_entry_a: assert property (
      $rose(O_MODE == dsm_pkg::DSM_D3) |-> $past(O_MODE) ==
      dsm_pkg::DSM_DP_ACT && !O_TMDS_SIGNALLING)
      else $error("bad d3 entry");
   hdmi_route_a: assert property (
      O_MODE == dsm_pkg::DSM_HDMI_ACT |-> O_HDMI_LINK_EN && O_DDC_BUFFER_EN
      && !O_DP_LINK_EN && !O_SRC_AUX_TO_SINK_AUX)
      else $error("hdmi outputs wrong");
   adpt_read_a: assert property (
      O_MODE == dsm_pkg::DSM_HDMI_ACT && I_DDC_RD &&
      I_DDC_DEV_ADDR == 8'h81 |-> ##2 O_ADPT_RVALID)
      else $error("id read unanswered");
endmodule
bind dsm_mode_ctrl dsm_mode_ctrl_chk #(.HPD_LOW_CYC(HPD_LOW_CYC)) chk (.*);
`default_nettype wire

// ==== tb/dsm_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// source aux side and both sinks' hot-plug lines
module dsm_far_model (
   input  wire logic  I_CLK,
   output logic       o_dp_hpd,
   output logic       o_hdmi_hpd,
   output logic       o_aux_valid,
   output logic [2:0] o_aux_cmd,
   output logic [1:0] o_aux_swing
);
   initial begin
      {o_dp_hpd, o_hdmi_hpd, o_aux_valid, o_aux_cmd, o_aux_swing} = '0;
   end
   task automatic plug(input logic dp, input logic hdmi);
      @(posedge I_CLK);
      o_dp_hpd <= dp;
      o_hdmi_hpd <= hdmi;
   endtask
   // short sink interrupt pulse
   task automatic irq(input int n);
      @(posedge I_CLK);
      o_dp_hpd <= 1'b0;
      repeat (n) @(posedge I_CLK);
      o_dp_hpd <= 1'b1;
   endtask
   task automatic aux(input logic [2:0] c, input logic [1:0] sw);
      @(posedge I_CLK);
      o_aux_valid <= 1'b1;
      o_aux_cmd <= c;
      o_aux_swing <= sw;
      @(posedge I_CLK);
      o_aux_valid <= 1'b0;
      // a released command bus must not keep looking valid
      o_aux_cmd <= ~c;
      o_aux_swing <= ~sw;
      repeat (3) @(posedge I_CLK);
      #1;
   endtask
endmodule
`default_nettype wire

// ==== tb/test_dsm_mode_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_dsm_mode_ctrl;
   localparam int unsigned LOW = 8;
   localparam logic [127:0] ID = {"DP-HDMI ADAPTOR", 8'h04};
   logic       I_CLK, I_RESET, I_CE, I_CHIP_EN, I_SINK_CABLE_DETECT_IN;
   logic       I_SINK_PREF, I_CFG_WR, I_CFG_TRAIN_DIS, I_CFG_OVR_EN;
   logic       I_DDC_WR, I_DDC_RD, I_AUX_VALID;
   logic       I_DP_SINK_HOTPLUG_IN, I_HDMI_SINK_HOTPLUG_IN;
   logic [1:0] I_EQ_CTRL, I_CFG_SWING, I_CFG_PREEMPH, I_CFG_EQ;
   logic [1:0] I_AUX_SWING, I_AUX_PREEMPH, O_SWING, O_PREEMPH, O_EQ;
   logic [2:0] I_AUX_CMD, O_MODE;
   logic [7:0] I_DDC_DEV_ADDR, I_DDC_WDATA, O_ADPT_RDATA;
   logic       O_SOURCE_HOTPLUG_OUT, O_SOURCE_CABLE_DETECT_OUT;
   logic       O_SOURCE_CABLE_DETECT_OE, O_DP_LINK_EN, O_HDMI_LINK_EN;
   logic       O_TMDS_SIGNALLING, O_SRC_DDC_TO_SINK_AUX, O_DDC_BUFFER_EN;
   logic       O_SRC_AUX_TO_SINK_AUX, O_I2C_ACTIVE, O_AUX_MON_ACTIVE;
   logic       O_ADPT_RVALID;
   int         fails, n_compared, i;
   dsm_mode_ctrl #(.HPD_LOW_CYC(LOW)) dut (.*);
   dsm_far_model far (
      .I_CLK       (I_CLK),
      .o_dp_hpd    (I_DP_SINK_HOTPLUG_IN),
      .o_hdmi_hpd  (I_HDMI_SINK_HOTPLUG_IN),
      .o_aux_valid (I_AUX_VALID),
      .o_aux_cmd   (I_AUX_CMD),
      .o_aux_swing (I_AUX_SWING)
   );
   initial begin
      I_CLK = 1'b0;
      forever #25 I_CLK = ~I_CLK;
   end
   task automatic finish_test();
      if (fails == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge I_CLK);
      #1;
   endtask
   task automatic wait_mode(input logic [2:0] m);
      for (int k = 0; k < 100 && O_MODE !== m; k++) tick(1);
      chk(O_MODE, m);
      if (O_MODE !== m) finish_test();
   endtask
   task automatic cfg(input logic ovr, dis, input logic [1:0] s);
      @(posedge I_CLK);
      {I_CFG_WR, I_CFG_OVR_EN} <= {1'b1, ovr};
      {I_CFG_TRAIN_DIS, I_CFG_SWING} <= {dis, s};
      @(posedge I_CLK);
      I_CFG_WR <= 1'b0;
      tick(3);
   endtask
   task automatic ddc(input logic rd, input logic [7:0] a, d);
      @(posedge I_CLK);
      {I_DDC_RD, I_DDC_WR, I_DDC_DEV_ADDR, I_DDC_WDATA} <= {rd, ~rd, a, d};
      @(posedge I_CLK);
      {I_DDC_RD, I_DDC_WR} <= 2'h0;
      for (int k = 0; k < 4 && O_ADPT_RVALID !== 1'b1 && rd; k++) tick(1);
   endtask
   task automatic t_shutdown();
      far.plug(1'b0, 1'b1);
      tick(4);
      chk(O_MODE, dsm_pkg::DSM_SHUTDOWN);
      chk(O_SOURCE_HOTPLUG_OUT, 1'b1);
      chk({O_SOURCE_CABLE_DETECT_OE, O_I2C_ACTIVE}, 2'h0);
   endtask
   task automatic t_dp();
      far.plug(1'b1, 1'b0);
      I_CHIP_EN <= 1'b1;
      wait_mode(dsm_pkg::DSM_STANDBY);
      wait_mode(dsm_pkg::DSM_DP_ACT);
      chk({O_TMDS_SIGNALLING, O_SRC_AUX_TO_SINK_AUX}, 2'h1);
      chk(O_DP_LINK_EN, 1'b0);
      far.aux(dsm_pkg::AUXC_TRAIN_SET, 2'h2);
      far.aux(dsm_pkg::AUXC_TRAIN_DONE, 2'h2);
      chk({O_DP_LINK_EN, O_SWING}, 3'h6);
      cfg(1'b0, 1'b1, 2'h0);
      chk(O_DP_LINK_EN, 1'b0);
      cfg(1'b1, 1'b1, 2'h3);
      chk({O_DP_LINK_EN, O_SWING}, 3'h7);
      cfg(1'b0, 1'b0, 2'h0);
      far.aux(3'h7, 2'h1);
      chk(O_MODE, dsm_pkg::DSM_DP_ACT);
      far.irq(LOW - 3);
      tick(LOW);
      chk(O_MODE, dsm_pkg::DSM_DP_ACT);
      far.aux(dsm_pkg::AUXC_ENTER_D3, 2'h0);
      wait_mode(dsm_pkg::DSM_D3);
      chk({O_DP_LINK_EN, O_AUX_MON_ACTIVE}, 2'h1);
      far.aux(dsm_pkg::AUXC_EXIT_D3, 2'h0);
      wait_mode(dsm_pkg::DSM_DP_ACT);
   endtask
   task automatic t_tmds();
      I_SINK_CABLE_DETECT_IN <= 1'b1;
      tick(4);
      chk({O_TMDS_SIGNALLING, O_SRC_DDC_TO_SINK_AUX}, 2'h3);
      chk(O_SOURCE_CABLE_DETECT_OUT, 1'b1);
      chk(O_SWING, dsm_pkg::SWING_600MV);
      far.aux(dsm_pkg::AUXC_ENTER_D3, 2'h0);
      chk(O_MODE, dsm_pkg::DSM_DP_ACT);
      cfg(1'b1, 1'b0, 2'h3);
      chk(O_SWING, 2'h3);
      I_CHIP_EN <= 1'b0;
      tick(4);
      I_CHIP_EN <= 1'b1;
      wait_mode(dsm_pkg::DSM_DP_ACT);
      chk(O_SWING, dsm_pkg::SWING_600MV);
   endtask
   task automatic t_pref();
      far.plug(1'b1, 1'b1);
      tick(LOW + 4);
      chk(O_MODE, dsm_pkg::DSM_DP_ACT);
      I_SINK_PREF <= 1'b1;
      wait_mode(dsm_pkg::DSM_STANDBY);
      wait_mode(dsm_pkg::DSM_HDMI_ACT);
      chk({O_HDMI_LINK_EN, O_DDC_BUFFER_EN}, 2'h3);
      ddc(1'b0, 8'h80, 8'h00);
      for (i = 0; i < 17; i++) begin
         ddc(1'b1, 8'h81, 8'h00);
         chk(O_ADPT_RDATA, i < 16 ? ID[127 - 8 * i -: 8] : 8'hff);
      end
      far.plug(1'b0, 1'b0);
      wait_mode(dsm_pkg::DSM_STANDBY);
   endtask
   initial begin
      fails = 0;
      n_compared = 0;
      {I_RESET, I_CE} = 2'h3;
      {I_CHIP_EN, I_SINK_CABLE_DETECT_IN, I_SINK_PREF, I_CFG_WR} = 4'h0;
      {I_CFG_TRAIN_DIS, I_CFG_OVR_EN, I_DDC_WR, I_DDC_RD} = 4'h0;
      {I_EQ_CTRL, I_CFG_SWING, I_CFG_PREEMPH, I_CFG_EQ, I_AUX_PREEMPH} = '0;
      {I_DDC_DEV_ADDR, I_DDC_WDATA} = 16'h0000;
      repeat (12) @(posedge I_CLK);
      I_RESET <= 1'b0;
      tick(2);
      t_shutdown();
      t_dp();
      t_tmds();
      t_pref();
      finish_test();
   end
endmodule
`default_nettype wire
